// >>> pkg/event_log_pkg.sv
package event_log_pkg;
  // ----------------------------------------------------------------
  // entry layout
  // ----------------------------------------------------------------
  localparam int LOG_DEPTH = 200;
  localparam int CHAN_W    = 8;
  localparam int NUM_W     = 4;
  localparam int CODE_W    = CHAN_W + NUM_W;
  localparam int DATE_W    = 16;
  localparam int TIME_W    = 27;
  localparam int FV_W      = 16;
  localparam int FT_W      = 4;
  localparam int MASK_W    = 32;
  localparam int ADDR_W    = 6;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [DATE_W-1:0] date;
    logic [TIME_W-1:0] time_ms;
    logic [FV_W-1:0]   fault_value;
    logic [FT_W-1:0]   fault_type;
  } entry_type;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CONTROL   = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK      = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_SCALE     = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT     = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_CLEAR     = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_NEXT      = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_LAST_CODE = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_LAST_DATE = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_LAST_TIME = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN    = 6'h2c;

  // control bits and reset values
  localparam int CTL_ORDER = 0;
  localparam int CTL_SCALE = 1;
  localparam int CTL_POPUP = 2;
  localparam logic [2:0]        CONTROL_RST = 3'h4;
  localparam logic [MASK_W-1:0] MASK_RST    = 32'h0;
  localparam logic [15:0]       SCALE_RST   = 16'h0001;
  localparam int NEXT_VALID_BIT = 31;

  // status bits
  localparam int ST_LOGGED = 0;
  localparam int ST_OVF    = 1;
endpackage : event_log_pkg

// >>> rtl/event_log_buffer.sv
`timescale 1ns/1ps
module event_log_buffer #(
  parameter int DEPTH = event_log_pkg::LOG_DEPTH
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  // avalon-mm slave
  input  wire logic [event_log_pkg::ADDR_W-1:0]  address,
  input  wire logic                              read,
  input  wire logic                              write,
  input  wire logic [31:0]                       writedata,
  output logic [31:0]                            readdata,
  output logic                                   waitrequest,
  output logic                                   irq,
  // event source
  input  wire logic                              event_valid,
  input  wire logic [event_log_pkg::CHAN_W-1:0]  event_channel,
  input  wire logic [event_log_pkg::NUM_W-1:0]   event_number,
  input  wire logic [event_log_pkg::DATE_W-1:0]  event_date,
  input  wire logic [event_log_pkg::TIME_W-1:0]  event_time_ms,
  input  wire logic [event_log_pkg::FV_W-1:0]    event_fault_value,
  input  wire logic [event_log_pkg::FT_W-1:0]    event_fault_type,
  // local panel
  input  wire logic                              panel_next,
  input  wire logic                              panel_prev,
  input  wire logic                              panel_ack,
  output logic                                   panel_valid,
  output logic [event_log_pkg::CODE_W-1:0]       panel_code,
  output logic [event_log_pkg::DATE_W-1:0]       panel_date,
  output logic [event_log_pkg::TIME_W-1:0]       panel_time_ms,
  output logic [31:0]                            panel_value,
  output logic [event_log_pkg::FT_W-1:0]         panel_fault_type,
  output logic                                   overflow_marker,
  output logic                                   alarm_popup
);
  import event_log_pkg::*;

  localparam int IW = $clog2(DEPTH + 1);

  typedef struct packed {
    entry_type [DEPTH-1:0] mem;
    logic [IW-1:0]         wr_ptr;
    logic [IW-1:0]         count;
    logic [IW-1:0]         unread;
    logic [IW-1:0]         browse;
    entry_type             last;
    logic [2:0]            control;
    logic [MASK_W-1:0]     mask;
    logic [15:0]           scale;
    logic [1:0]            status;
    logic [1:0]            irq_en;
    logic                  ovf;
    logic                  ack;
    logic [31:0]           rdata;
    logic                  popup;
    logic                  pvalid;
    entry_type             pentry;
    logic [31:0]           pvalue;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic      req;
  logic      clr;
  logic      pop;
  logic      masked;
  logic      logged;
  logic      ovf_ev;
  entry_type new_entry;
  entry_type shown;

  function automatic logic [IW-1:0] wrap(input logic [IW:0] a);
    return (a >= (IW+1)'(DEPTH)) ? IW'(a - (IW+1)'(DEPTH)) : a[IW-1:0];
  endfunction : wrap

  // distance back from the write pointer, k in 1..DEPTH
  function automatic logic [IW-1:0] back(input logic [IW-1:0] wr, input logic [IW-1:0] k);
    return wrap({1'b0, wr} + (IW+1)'(DEPTH) - {1'b0, k});
  endfunction : back

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [IW-1:0] unread_mid;
    logic [IW-1:0] phys;
    s_d        = s_q;
    unread_mid = s_q.unread;
    phys       = '0;
    clr        = 1'b0;
    pop        = 1'b0;
    logged     = 1'b0;
    ovf_ev     = 1'b0;
    req        = (read | write) & ~s_q.ack;
    // code is channel then number; stamp in ms even for coarse sources
    new_entry  = '{code: {event_channel, event_number}, date: event_date,
                   time_ms: event_time_ms, fault_value: event_fault_value,
                   fault_type: event_fault_type};
    // only the low channels have a mask bit; higher ones always log
    masked     = (event_channel < CHAN_W'(MASK_W)) && s_q.mask[event_channel[4:0]];

    // register writes
    if (req && write)
    begin
      unique case (address)
        OFF_CONTROL:   s_d.control = writedata[2:0];
        OFF_MASK:      s_d.mask = writedata;
        OFF_SCALE:     s_d.scale = writedata[15:0];
        OFF_CLEAR:     clr = writedata[0];
        OFF_IRQ_CLEAR: s_d.status = s_q.status & ~writedata[1:0];
        OFF_IRQ_EN:    s_d.irq_en = writedata[1:0];
        default:       ;
      endcase
    end

    // register reads; bus sees code, date and time only
    if (req && read)
    begin
      s_d.rdata = 32'h0;
      unique case (address)
        OFF_CONTROL:   s_d.rdata = {29'h0, s_q.control};
        OFF_MASK:      s_d.rdata = s_q.mask;
        OFF_SCALE:     s_d.rdata = {16'h0, s_q.scale};
        OFF_COUNT:     s_d.rdata = 32'(s_q.count);
        OFF_NEXT:
        begin
          if (s_q.unread != '0)
          begin
            pop        = 1'b1;
            s_d.last   = s_q.mem[back(s_q.wr_ptr, s_q.unread)];
            s_d.rdata  = 32'(s_d.last.code);
            s_d.rdata[NEXT_VALID_BIT] = 1'b1;
            unread_mid = s_q.unread - 1'b1;
          end
        end
        OFF_LAST_CODE: s_d.rdata = 32'(s_q.last.code);
        OFF_LAST_DATE: s_d.rdata = 32'(s_q.last.date);
        OFF_LAST_TIME: s_d.rdata = 32'(s_q.last.time_ms);
        OFF_STATUS:    s_d.rdata = {30'h0, s_q.status};
        OFF_IRQ_EN:    s_d.rdata = {30'h0, s_q.irq_en};
        default:       ;
      endcase
    end
    s_d.ack    = req;
    s_d.unread = unread_mid;

    // ring update; clear wins over an event in the same cycle
    if (clr)
    begin
      s_d.wr_ptr = '0;
      s_d.count  = '0;
      s_d.unread = '0;
      s_d.browse = '0;
      s_d.ovf    = 1'b0;
    end
    else if (event_valid && !masked)
    begin
      logged = 1'b1;
      s_d.mem[s_q.wr_ptr] = new_entry;
      s_d.wr_ptr = wrap({1'b0, s_q.wr_ptr} + 1'b1);
      if (s_q.count != IW'(DEPTH))
        s_d.count = s_q.count + 1'b1;
      if (unread_mid == IW'(DEPTH))
        ovf_ev = 1'b1;
      else
        s_d.unread = unread_mid + 1'b1;
    end
    s_d.ovf = s_d.ovf | ovf_ev;
    // hardware set wins over a same-cycle software clear
    s_d.status = s_d.status | {ovf_ev, logged};

    // alarm pop-up
    if (!s_q.control[CTL_POPUP])
      s_d.popup = 1'b0;
    else if (logged)
      s_d.popup = 1'b1;
    else if (panel_ack)
      s_d.popup = 1'b0;

    // panel browsing, independent of the remote pointer
    if (!clr)
    begin
      if (panel_next && !panel_prev && ({1'b0, s_q.browse} + 1'b1 < {1'b0, s_q.count}))
        s_d.browse = s_q.browse + 1'b1;
      else if (panel_prev && !panel_next && s_q.browse != '0)
        s_d.browse = s_q.browse - 1'b1;
    end
    if (s_q.control[CTL_ORDER])
      phys = back(s_q.wr_ptr, s_q.browse + 1'b1);
    else
      phys = wrap({1'b0, back(s_q.wr_ptr, s_q.count)} + {1'b0, s_q.browse});
    shown      = s_q.mem[phys];
    s_d.pvalid = (s_q.count != '0);
    s_d.pentry = shown;
    // primary value is per unit times the nominal factor
    s_d.pvalue = s_q.control[CTL_SCALE] ? 32'(shown.fault_value) * 32'(s_q.scale)
                                        : 32'(shown.fault_value);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q         <= '0;
      s_q.control <= CONTROL_RST;
      s_q.mask    <= MASK_RST;
      s_q.scale   <= SCALE_RST;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // answer comes one cycle after the request is first seen
  assign waitrequest      = (read | write) & ~s_q.ack;
  assign readdata         = s_q.rdata;
  assign irq              = |(s_q.status & s_q.irq_en);
  assign panel_valid      = s_q.pvalid;
  assign panel_code       = s_q.pentry.code;
  assign panel_date       = s_q.pentry.date;
  assign panel_time_ms    = s_q.pentry.time_ms;
  assign panel_fault_type = s_q.pentry.fault_type;
  assign panel_value      = s_q.pvalue;
  assign overflow_marker  = s_q.ovf;
  assign alarm_popup      = s_q.popup;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_bus_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_bus_done;
    !waitrequest ##1 waitrequest || !(read || write);
  endsequence

  property p_bus_answer;
    s_bus_req |=> s_bus_done;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one cycle");

  property p_count_step;
    logged && s_q.count != IW'(DEPTH) |=> s_q.count == $past(s_q.count) + 1'b1 && s_q.count <= IW'(DEPTH);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_mask_drop;
    event_valid && masked && !clr |=> s_q.wr_ptr == $past(s_q.wr_ptr);
  endproperty
  a_mask_drop: assert property (p_mask_drop) else $error("masked event stored");

  property p_next_pop;
    req && read && address == OFF_NEXT && s_q.unread != '0 && !event_valid && !clr
      |=> s_q.unread == $past(s_q.unread) - 1'b1 && readdata[NEXT_VALID_BIT];
  endproperty
  a_next_pop: assert property (p_next_pop) else $error("next read did not advance");

  property p_reread;
    req && read && address == OFF_LAST_CODE && !event_valid
      |=> s_q.unread == $past(s_q.unread) && readdata == 32'(s_q.last.code);
  endproperty
  a_reread: assert property (p_reread) else $error("reread moved pointer");

  sequence s_overwrite;
    event_valid && !masked && !clr && s_q.unread == IW'(DEPTH) && !pop;
  endsequence
  property p_overflow;
    s_overwrite |=> overflow_marker && s_q.status[ST_OVF] ##1 overflow_marker || $past(clr);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_clear;
    clr |=> s_q.count == '0 && s_q.unread == '0 && !overflow_marker;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left entries");

  property p_popup_off;
    !s_q.control[CTL_POPUP] |=> !alarm_popup;
  endproperty
  a_popup_off: assert property (p_popup_off) else $error("pop-up while disabled");

  property p_per_unit;
    !s_q.control[CTL_SCALE] |=> panel_value == 32'(s_q.pentry.fault_value);
  endproperty
  a_per_unit: assert property (p_per_unit) else $error("per unit value scaled");
endmodule : event_log_buffer

// >>> verif/event_log_buffer_tb.sv
`timescale 1ns/1ps
module event_log_buffer_tb;
  import event_log_pkg::*;
  // small ring so overwrite is reached quickly
  localparam int DEPTH = 4;
  logic clk = 0;
  logic reset_n = 0;
  logic [ADDR_W-1:0] address;
  logic read, write, waitrequest, irq, timed_out;
  logic [31:0] writedata, readdata, q;
  logic event_valid = 0;
  logic [CHAN_W-1:0] event_channel = 0;
  logic [NUM_W-1:0] event_number = 0;
  logic [DATE_W-1:0] event_date;
  logic [TIME_W-1:0] event_time_ms;
  logic [FV_W-1:0] event_fault_value;
  logic [FT_W-1:0] event_fault_type, panel_fault_type;
  logic panel_next = 0, panel_prev = 0, panel_ack = 0;
  logic panel_valid, overflow_marker, alarm_popup;
  logic [CODE_W-1:0] panel_code;
  logic [DATE_W-1:0] panel_date;
  logic [TIME_W-1:0] panel_time_ms;
  logic [31:0] panel_value;
  int n_fail = 0;
  int checks = 0;
  // event fields derived from the code; 10 ms stamp steps
  assign event_date = {4'h7, event_number, event_channel};
  assign event_time_ms = TIME_W'(event_channel) * 27'd1000 + TIME_W'(event_number) * 27'd10;
  assign event_fault_value = {4'h0, event_channel, event_number};
  assign event_fault_type = event_number;
  initial
  begin
    forever #5 clk = ~clk;
  end
  event_log_buffer #(.DEPTH(DEPTH)) DUT (.clk, .reset_n, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .irq, .event_valid, .event_channel, .event_number, .event_date, .event_time_ms,
    .event_fault_value, .event_fault_type, .panel_next, .panel_prev, .panel_ack, .panel_valid, .panel_code,
    .panel_date, .panel_time_ms, .panel_value, .panel_fault_type, .overflow_marker, .alarm_popup);
  event_reader u_rdr (.clk, .waitrequest, .readdata, .address, .read, .write, .writedata, .timed_out);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict();
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic bus_done();
    if (timed_out)
    begin
      n_fail++;
      print_verdict();
    end
  endtask : bus_done
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    u_rdr.xfer(1'b1, a, d, q);
    bus_done();
  endtask : wr
  task automatic rc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    u_rdr.reread(a, q);
    bus_done();
    chk(nm, q, e);
  endtask : rc
  task automatic push(input logic [7:0] c, input logic [3:0] n);
    event_channel <= c;
    event_number <= n;
    event_valid <= 1'b1;
    @(posedge clk);
    event_valid <= 1'b0;
    tick(3);
  endtask : push
  task automatic step(input logic n, input logic p);
    panel_next <= n;
    panel_prev <= p;
    @(posedge clk);
    panel_next <= 1'b0;
    panel_prev <= 1'b0;
    tick(3);
  endtask : step
  initial
  begin
    tick(100000);
    n_fail++;
    print_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    tick(3);
    reset_n <= 1'b1;
    rc("control", OFF_CONTROL, 32'h4);
    rc("mask", OFF_MASK, 32'h0);
    rc("scale", OFF_SCALE, 32'h1);
    rc("count", OFF_COUNT, 32'h0);
    rc("unmapped", 6'h30, 32'h0);
    push(8'h1e, 4'h2);
    chk("popup", alarm_popup, 32'h1);
    chk("pcode", panel_code, 32'h1e2);
    chk("pdate", panel_date, 32'h721e);
    chk("ptime", panel_time_ms, 32'd30020);
    chk("pvalue", panel_value, 32'h1e2);
    chk("ptype", panel_fault_type, 32'h2);
    chk("pvalid", panel_valid, 32'h1);
    wr(OFF_SCALE, 32'h3);
    wr(OFF_CONTROL, 32'h6);
    tick(2);
    chk("pvalue", panel_value, 32'h5a6);
    u_rdr.pop(q);
    chk("next", q, 32'h800001e2);
    repeat (2) rc("last", OFF_LAST_CODE, 32'h1e2);
    rc("ldate", OFF_LAST_DATE, 32'h721e);
    rc("ltime", OFF_LAST_TIME, 32'd30020);
    rc("next", OFF_NEXT, 32'h0);
    panel_ack <= 1'b1;
    @(posedge clk);
    panel_ack <= 1'b0;
    tick(2);
    chk("popup", alarm_popup, 32'h0);
    wr(OFF_MASK, 32'h8);
    push(8'h3, 4'h1);
    rc("count", OFF_COUNT, 32'h1);
    wr(OFF_MASK, 32'h0);
    wr(OFF_IRQ_EN, 32'h1);
    tick(2);
    chk("irq", irq, 32'h1);
    wr(OFF_IRQ_CLEAR, 32'h1);
    tick(2);
    chk("irq", irq, 32'h0);
    rc("status", OFF_STATUS, 32'h0);
    wr(OFF_CONTROL, 32'h0);
    push(8'h4, 4'h4);
    chk("popup", alarm_popup, 32'h0);
    chk("irq", irq, 32'h1);
    wr(OFF_IRQ_EN, 32'h0);
    tick(2);
    chk("irq", irq, 32'h0);
    wr(OFF_CLEAR, 32'h1);
    rc("count", OFF_COUNT, 32'h0);
    tick(2);
    chk("pvalid", panel_valid, 32'h0);
    // the oldest unread entry is overwritten by the last push
    for (int i = 1; i <= DEPTH + 1; i++)
      push(8'(i), 4'(i));
    chk("ovf", overflow_marker, 32'h1);
    rc("status", OFF_STATUS, 32'h3);
    rc("count", OFF_COUNT, DEPTH);
    // overflow alone raises the interrupt; its clear drops it again
    wr(OFF_IRQ_EN, 32'h2);
    tick(2);
    chk("irq", irq, 32'h1);
    wr(OFF_IRQ_CLEAR, 32'h2);
    tick(2);
    chk("irq", irq, 32'h0);
    chk("ovf", overflow_marker, 32'h1);
    wr(OFF_IRQ_EN, 32'h0);
    chk("pcode", panel_code, 32'h22);
    wr(OFF_CONTROL, 32'h1);
    tick(2);
    chk("pcode", panel_code, 32'h55);
    step(1'b1, 1'b0);
    chk("pcode", panel_code, 32'h44);
    step(1'b0, 1'b1);
    chk("pcode", panel_code, 32'h55);
    u_rdr.pop(q);
    chk("next", q, 32'h80000022);
    wr(OFF_CLEAR, 32'h1);
    rc("count", OFF_COUNT, 32'h0);
    chk("ovf", overflow_marker, 32'h0);
    rc("next", OFF_NEXT, 32'h0);
    print_verdict();
  end
endmodule : event_log_buffer_tb

// >>> verif/event_reader.sv
`timescale 1ns/1ps
module event_reader (
  // clock
  input  wire logic                             clk,
  // avalon-mm master side
  input  wire logic                             waitrequest,
  input  wire logic [31:0]                      readdata,
  output logic      [event_log_pkg::ADDR_W-1:0] address,
  output logic                                  read,
  output logic                                  write,
  output logic      [31:0]                      writedata,
  output logic                                  timed_out
);
  import event_log_pkg::*;
  initial
  begin
    {read, write, address, writedata, timed_out} = '0;
  end
  // ----------------------------------------
  // bus cycle: held until waitrequest is seen low or 50 cycles pass
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= w ? d : 32'h0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    timed_out = (n >= 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : xfer
  // one read pops at most one unread entry
  task automatic pop(output logic [31:0] q);
    xfer(1'b0, OFF_NEXT, 32'h0, q);
  endtask : pop
  // repeat access after a link error, pointer untouched for any address but OFF_NEXT
  task automatic reread(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : reread
endmodule : event_reader
